// [hdl/sofm_pkg.sv]
// Package: constants and types for the status output routing and fan monitor
package sofm_pkg;

  localparam int unsigned SEL_W = 7;

  // Selection codes
  localparam logic [6:0] SEL_RUNNING      = 7'h00;
  localparam logic [6:0] SEL_AT_TARGET    = 7'h01;
  localparam logic [6:0] SEL_OVERLOAD     = 7'h03;
  localparam logic [6:0] SEL_FREQ_DETECT  = 7'h04;
  localparam logic [6:0] SEL_READY        = 7'h0b;
  localparam logic [6:0] SEL_CURR_DETECT  = 7'h0c;
  localparam logic [6:0] SEL_ZERO_CURR    = 7'h0d;
  localparam logic [6:0] SEL_MINOR_FAULT  = 7'h62;
  localparam logic [6:0] SEL_MAJOR_FAULT  = 7'h63;

  // Reset defaults of the three selection settings
  localparam logic [6:0] OUT_A_SEL_RST    = 7'h00;
  localparam logic [6:0] OUT_B_SEL_RST    = 7'h04;
  localparam logic [6:0] RELAY_SEL_RST    = 7'h63;

  // Mode encodings
  localparam logic FAN_MODE_ALWAYS        = 1'b0;
  localparam logic FAN_MODE_TEMP          = 1'b1;
  localparam logic GND_CHECK_OFF          = 1'b0;
  localparam logic GND_CHECK_RST          = 1'b0;

  // Alarm code reported for a ground fault at start (arbitrary encoding)
  localparam logic [7:0] GROUND_FAULT_ALARM_CODE = 8'h01;

  // Start check timing
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned GND_CHECK_MS    = 20;
  localparam int unsigned GND_CHECK_CYC   = (CLK_HZ / 1000) * GND_CHECK_MS;
  localparam int unsigned CNT_W           = 18;

  typedef enum logic [1:0] {
    SOFM_IDLE,
    SOFM_CHECK,
    SOFM_RUN,
    SOFM_TRIP
  } sofm_state_e;

endpackage

// [hdl/sofm_select.sv]
// Code-to-indication selector for one output point
`timescale 1ns/1ps
`default_nettype none
module sofm_select
  import sofm_pkg::*;
(
  input  wire logic [SEL_W-1:0] sel_i,
  input  wire logic             running_i,
  input  wire logic             at_target_frequency_i,
  input  wire logic             overload_alarm_i,
  input  wire logic             output_frequency_detect_i,
  input  wire logic             operation_ready_i,
  input  wire logic             output_current_detect_i,
  input  wire logic             zero_current_detect_i,
  input  wire logic             minor_fault_flag_i,
  input  wire logic             major_fault_i,
  output logic                  point_o
);
  always_comb begin
    case (sel_i)
      SEL_RUNNING:     point_o = running_i;
      SEL_AT_TARGET:   point_o = at_target_frequency_i;
      SEL_OVERLOAD:    point_o = overload_alarm_i;
      SEL_FREQ_DETECT: point_o = output_frequency_detect_i;
      SEL_READY:       point_o = operation_ready_i;
      SEL_CURR_DETECT: point_o = output_current_detect_i;
      SEL_ZERO_CURR:   point_o = zero_current_detect_i;
      SEL_MINOR_FAULT: point_o = minor_fault_flag_i;
      SEL_MAJOR_FAULT: point_o = major_fault_i;
      default:         point_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [hdl/sofm_top.sv]
// Status output routing, cooling fan control and ground check at start
`timescale 1ns/1ps
`default_nettype none
module sofm_top
  import sofm_pkg::*;
#(
  parameter int unsigned CHECK_CYCLES = GND_CHECK_CYC
)(
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic [SEL_W-1:0]    output_a_select_i,
  input  wire logic [SEL_W-1:0]    output_b_select_i,
  input  wire logic [SEL_W-1:0]    relay_output_select_i,
  input  wire logic                fan_mode_setting_i,
  input  wire logic                ground_check_enable_i,
  input  wire logic                start_cmd_i,
  input  wire logic                freq_at_start_i,
  input  wire logic                at_target_frequency_i,
  input  wire logic                overload_alarm_i,
  input  wire logic                output_frequency_detect_i,
  input  wire logic                operation_ready_i,
  input  wire logic                output_current_detect_i,
  input  wire logic                zero_current_detect_i,
  input  wire logic                protect_trip_i,
  input  wire logic                fan_running_i,
  input  wire logic                temp_high_i,
  input  wire logic                ground_fault_sense_i,
  input  wire logic                fault_reset_i,
  output logic                     output_a_o,
  output logic                     output_b_o,
  output logic                     major_fault_contact_o,
  output logic                     remote_input_slot_a_o,
  output logic                     remote_input_slot_b_o,
  output logic                     remote_input_slot_c_o,
  output logic                     fan_on_o,
  output logic                     minor_fault_flag_o,
  output logic                     drive_enable_o,
  output logic                     ground_fault_alarm_o,
  output logic [7:0]               alarm_code_o
);
  import sofm_pkg::*;

  typedef struct packed {
    sofm_state_e      state;
    logic [CNT_W-1:0] cnt;
    logic             start_d;
    logic             gf_trip;
    logic [7:0]       alarm_code;
    logic             fan_on;
    logic             fan_fault;
    logic             drive_en;
    logic [2:0]       points;
  } sofm_s;

  sofm_s st_reg;
  sofm_s st_next;

  localparam logic [CNT_W-1:0] CHECK_LAST = CNT_W'(CHECK_CYCLES - 1);

  logic running;
  logic major_fault;
  logic pt_a;
  logic pt_b;
  logic pt_c;

  // Running means powered output above the starting frequency
  assign running     = st_reg.drive_en & freq_at_start_i;
  assign major_fault = protect_trip_i | st_reg.gf_trip;

  // Same selector per point lets any code appear on several points
  sofm_select u_sel_a (
    .sel_i                     (output_a_select_i),
    .running_i                 (running),
    .at_target_frequency_i     (at_target_frequency_i),
    .overload_alarm_i          (overload_alarm_i),
    .output_frequency_detect_i (output_frequency_detect_i),
    .operation_ready_i         (operation_ready_i),
    .output_current_detect_i   (output_current_detect_i),
    .zero_current_detect_i     (zero_current_detect_i),
    .minor_fault_flag_i        (st_reg.fan_fault),
    .major_fault_i             (major_fault),
    .point_o                   (pt_a)
  );
  sofm_select u_sel_b (
    .sel_i                     (output_b_select_i),
    .running_i                 (running),
    .at_target_frequency_i     (at_target_frequency_i),
    .overload_alarm_i          (overload_alarm_i),
    .output_frequency_detect_i (output_frequency_detect_i),
    .operation_ready_i         (operation_ready_i),
    .output_current_detect_i   (output_current_detect_i),
    .zero_current_detect_i     (zero_current_detect_i),
    .minor_fault_flag_i        (st_reg.fan_fault),
    .major_fault_i             (major_fault),
    .point_o                   (pt_b)
  );
  sofm_select u_sel_c (
    .sel_i                     (relay_output_select_i),
    .running_i                 (running),
    .at_target_frequency_i     (at_target_frequency_i),
    .overload_alarm_i          (overload_alarm_i),
    .output_frequency_detect_i (output_frequency_detect_i),
    .operation_ready_i         (operation_ready_i),
    .output_current_detect_i   (output_current_detect_i),
    .zero_current_detect_i     (zero_current_detect_i),
    .minor_fault_flag_i        (st_reg.fan_fault),
    .major_fault_i             (major_fault),
    .point_o                   (pt_c)
  );

  always_comb begin
    st_next         = st_reg;
    st_next.start_d = start_cmd_i;
    st_next.points  = {pt_c, pt_b, pt_a};

    case (st_reg.state)
      SOFM_IDLE: begin
        st_next.drive_en = 1'b0;
        if (start_cmd_i && !st_reg.start_d && !protect_trip_i) begin
          if (ground_check_enable_i != GND_CHECK_OFF) begin
            st_next.state = SOFM_CHECK;
            st_next.cnt   = '0;
          end else begin
            st_next.state    = SOFM_RUN;
            st_next.drive_en = 1'b1;
          end
        end
      end
      SOFM_CHECK: begin
        // Output stays off for the whole check window
        st_next.drive_en = 1'b0;
        if (ground_fault_sense_i) begin
          st_next.state      = SOFM_TRIP;
          st_next.gf_trip    = 1'b1;
          st_next.alarm_code = GROUND_FAULT_ALARM_CODE;
        end else if (!start_cmd_i) begin
          st_next.state = SOFM_IDLE;
        end else if (st_reg.cnt == CHECK_LAST) begin
          st_next.state    = SOFM_RUN;
          st_next.drive_en = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
      SOFM_RUN: begin
        // Ground sense is ignored once running
        if (!start_cmd_i || protect_trip_i) begin
          st_next.state    = SOFM_IDLE;
          st_next.drive_en = 1'b0;
        end
      end
      SOFM_TRIP: begin
        st_next.drive_en = 1'b0;
        if (fault_reset_i) begin
          st_next.state      = SOFM_IDLE;
          st_next.gf_trip    = 1'b0;
          st_next.alarm_code = 8'h00;
        end
      end
      default: begin
        st_next.state    = SOFM_IDLE;
        st_next.drive_en = 1'b0;
      end
    endcase

    // Fan command and fault monitor
    if (fan_mode_setting_i == FAN_MODE_ALWAYS) begin
      st_next.fan_on    = 1'b1;
      st_next.fan_fault = !fan_running_i;
    end else begin
      st_next.fan_on    = running | temp_high_i;
      // Fan is judged against the previous command to allow the registered output
      st_next.fan_fault = running && (st_reg.fan_on != fan_running_i);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg            <= '0;
      st_reg.state      <= SOFM_IDLE;
      st_reg.fan_on     <= 1'b1;
      st_reg.points     <= 3'b000;
    end else begin
      st_reg <= st_next;
    end
  end

  assign output_a_o            = st_reg.points[0];
  assign output_b_o            = st_reg.points[1];
  assign major_fault_contact_o = st_reg.points[2];
  assign remote_input_slot_a_o = st_reg.points[0];
  assign remote_input_slot_b_o = st_reg.points[1];
  assign remote_input_slot_c_o = st_reg.points[2];
  assign fan_on_o              = st_reg.fan_on;
  assign minor_fault_flag_o    = st_reg.fan_fault;
  assign drive_enable_o        = st_reg.drive_en;
  assign ground_fault_alarm_o  = st_reg.gf_trip;
  assign alarm_code_o          = st_reg.alarm_code;
endmodule
`default_nettype wire

// [testbench/sofm_top_properties.sv]
// Port-level checker for the status routing and fan monitor
`timescale 1ns/1ps
`default_nettype none
module sofm_top_properties
  import sofm_pkg::*;
#(parameter int unsigned CHECK_CYCLES = 8)(
  input wire logic             core_clk_i, rst_i, fan_mode_setting_i, ground_check_enable_i,
  input wire logic             start_cmd_i, overload_alarm_i, operation_ready_i, protect_trip_i,
  input wire logic             fan_running_i, ground_fault_sense_i, output_a_o, output_b_o,
  input wire logic             major_fault_contact_o, remote_input_slot_a_o, fan_on_o,
  input wire logic             minor_fault_flag_o, drive_enable_o, ground_fault_alarm_o,
  input wire logic [SEL_W-1:0] output_a_select_i, output_b_select_i, relay_output_select_i,
  input wire logic [7:0]       alarm_code_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Only an idle, untripped drive takes a start edge
  sequence s_start;
    $rose(start_cmd_i) && !drive_enable_o && !ground_fault_alarm_o && !protect_trip_i;
  endsequence
  property p_mirror; remote_input_slot_a_o == output_a_o; endproperty
  a_mirror: assert property (p_mirror)
    else $error("slot a differs from point a");
  property p_ovl; output_a_select_i == SEL_OVERLOAD |=> output_a_o == $past(overload_alarm_i);
  endproperty
  a_ovl: assert property (p_ovl)
    else $error("overload not routed");
  property p_ready; output_b_select_i == SEL_READY |=> output_b_o == $past(operation_ready_i);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready not routed");
  property p_undef; relay_output_select_i == 7'h02 |=> !major_fault_contact_o; endproperty
  a_undef: assert property (p_undef)
    else $error("undefined code drives relay");
  property p_major;
    relay_output_select_i == SEL_MAJOR_FAULT && protect_trip_i |=> major_fault_contact_o;
  endproperty
  a_major: assert property (p_major)
    else $error("trip not on relay");
  property p_fan0; !fan_mode_setting_i |=> fan_on_o; endproperty
  a_fan0: assert property (p_fan0)
    else $error("fan off in mode 0");
  property p_fanflt; !fan_mode_setting_i && !fan_running_i |=> minor_fault_flag_o; endproperty
  a_fanflt: assert property (p_fanflt)
    else $error("stopped fan not flagged");
  property p_hold; s_start ##0 ground_check_enable_i |=> !drive_enable_o [*8]; endproperty
  a_hold: assert property (p_hold)
    else $error("output not held during check");
  property p_nochk; s_start ##0 !ground_check_enable_i |-> ##[1:2] drive_enable_o; endproperty
  a_nochk: assert property (p_nochk)
    else $error("start without check too slow");
  property p_late; drive_enable_o |=> !$rose(ground_fault_alarm_o); endproperty
  a_late: assert property (p_late)
    else $error("ground trip while running");
  property p_trip;
    $rose(ground_fault_alarm_o) |-> $past(ground_fault_sense_i) && !drive_enable_o
      && alarm_code_o == GROUND_FAULT_ALARM_CODE;
  endproperty
  a_trip: assert property (p_trip)
    else $error("ground trip without cause or code");
endmodule
bind sofm_top sofm_top_properties #(.CHECK_CYCLES(CHECK_CYCLES)) sofm_top_properties_i (.*);
`default_nettype wire

// [testbench/sofm_fan_model.sv]
// Cooling fan model: the tach follows the command one cycle late
`timescale 1ns/1ps
`default_nettype none
module sofm_fan_model (
  input  wire logic clk_i,
  input  wire logic fan_cmd_i,
  input  wire logic stall_i,
  output var logic  spinning_o
);
  // A rotor lags its command; a stalled one never spins
  initial spinning_o = 1'h1;
  always @(posedge clk_i) spinning_o <= fan_cmd_i && !stall_i;
endmodule
`default_nettype wire

// [testbench/status_output_routing_fan_monitor_tb.sv]
// Self-checking bench for the status routing and fan monitor
`timescale 1ns/1ps
`default_nettype none
module status_output_routing_fan_monitor_tb;
  import sofm_pkg::*;
  logic core_clk_i = 0, rst_i = 1, fan_mode_setting_i = 0, ground_check_enable_i = 0;
  logic start_cmd_i = 0, freq_at_start_i = 0, protect_trip_i = 0, temp_high_i = 0;
  logic ground_fault_sense_i = 0, fault_reset_i = 0, stall = 0, fan_running_i, e;
  logic at_target_frequency_i, overload_alarm_i, output_frequency_detect_i;
  logic operation_ready_i, output_current_detect_i, zero_current_detect_i;
  logic [5:0] src = 0;
  logic [SEL_W-1:0] output_a_select_i = OUT_A_SEL_RST, output_b_select_i = OUT_B_SEL_RST;
  logic [SEL_W-1:0] relay_output_select_i = RELAY_SEL_RST;
  logic output_a_o, output_b_o, major_fault_contact_o, remote_input_slot_a_o;
  logic remote_input_slot_b_o, remote_input_slot_c_o, fan_on_o, minor_fault_flag_o;
  logic drive_enable_o, ground_fault_alarm_o;
  logic [7:0] alarm_code_o;
  int err_total = 0, check_count = 0;
  // Rows: code, indications {target,ovl,fdet,ready,cdet,zero}, expected point
  localparam logic [13:0] ROWS [17] = '{
    {7'h01,6'h20,1'h1}, {7'h01,6'h1f,1'h0}, {7'h03,6'h10,1'h1}, {7'h03,6'h2f,1'h0},
    {7'h04,6'h08,1'h1}, {7'h04,6'h37,1'h0}, {7'h0b,6'h04,1'h1}, {7'h0b,6'h3b,1'h0},
    {7'h0c,6'h02,1'h1}, {7'h0c,6'h3d,1'h0}, {7'h0d,6'h01,1'h1}, {7'h0d,6'h3e,1'h0},
    {7'h02,6'h3f,1'h0}, {7'h32,6'h3f,1'h0}, {7'h61,6'h3f,1'h0}, {7'h62,6'h3f,1'h0},
    {7'h63,6'h3f,1'h0}};
  assign {at_target_frequency_i, overload_alarm_i, output_frequency_detect_i,
          operation_ready_i, output_current_detect_i, zero_current_detect_i} = src;
  sofm_top #(.CHECK_CYCLES(8)) sofm_top_i (.*);
  sofm_fan_model sofm_fan_model_i (.clk_i(core_clk_i), .fan_cmd_i(fan_on_o), .stall_i(stall),
                                   .spinning_o(fan_running_i));
  initial forever #50 core_clk_i = ~core_clk_i;
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #50_000;
    err_total++;
    summarize;
  end
  initial begin
    cyc(6);
    rst_i = 0;
    cyc(1);
    chk("fan on", 1, fan_on_o);
    src = 6'h08;
    cyc(2);
    chk("default b", 1, output_b_o);
    chk("default a", 0, output_a_o);
    chk("default relay", 0, major_fault_contact_o);
    $display("reset test done");
    for (int r = 0; r < 17; r++) begin
      {output_a_select_i, src, e} = ROWS[r];
      output_b_select_i = output_a_select_i;
      relay_output_select_i = output_a_select_i;
      cyc(2);
      chk("point a", e, output_a_o);
      chk("point b", e, output_b_o);
      chk("relay", e, major_fault_contact_o);
      chk("slot c", e, remote_input_slot_c_o);
      chk("slot b", e, remote_input_slot_b_o);
    end
    $display("routing table done");
    {output_a_select_i, output_b_select_i, relay_output_select_i} = {7'h00, 7'h62, 7'h63};
    src = 0;
    start_cmd_i = 1;
    freq_at_start_i = 1;
    cyc(3);
    chk("drive no check", 1, drive_enable_o);
    chk("running", 1, output_a_o);
    ground_fault_sense_i = 1;
    cyc(3);
    chk("late fault", 0, ground_fault_alarm_o);
    ground_fault_sense_i = 0;
    start_cmd_i = 0;
    ground_check_enable_i = 1;
    cyc(3);
    start_cmd_i = 1;
    cyc(5);
    chk("drive held", 0, drive_enable_o);
    cyc(8);
    chk("drive after check", 1, drive_enable_o);
    start_cmd_i = 0;
    cyc(3);
    start_cmd_i = 1;
    cyc(3);
    ground_fault_sense_i = 1;
    cyc(3);
    chk("gf alarm", 1, ground_fault_alarm_o);
    chk("gf code", GROUND_FAULT_ALARM_CODE, alarm_code_o);
    chk("gf drive", 0, drive_enable_o);
    chk("gf relay", 1, major_fault_contact_o);
    {ground_fault_sense_i, start_cmd_i, fault_reset_i} = 3'h1;
    cyc(2);
    fault_reset_i = 0;
    protect_trip_i = 1;
    cyc(2);
    chk("alarm cleared", 0, ground_fault_alarm_o);
    chk("trip relay", 1, major_fault_contact_o);
    protect_trip_i = 0;
    $display("start check tests done");
    stall = 1;
    cyc(4);
    chk("fan fault", 1, minor_fault_flag_o);
    chk("minor point", 1, output_b_o);
    stall = 0;
    cyc(4);
    chk("fan ok", 0, output_b_o);
    {fan_mode_setting_i, temp_high_i} = 2'h3;
    cyc(3);
    chk("fan hot", 1, fan_on_o);
    temp_high_i = 0;
    cyc(3);
    chk("fan cool", 0, fan_on_o);
    chk("stopped no fault", 0, minor_fault_flag_o);
    {ground_check_enable_i, start_cmd_i, stall} = 3'h3;
    cyc(6);
    chk("run fan on", 1, fan_on_o);
    chk("run fan stuck", 1, minor_fault_flag_o);
    $display("fan tests done");
    summarize;
  end
endmodule
`default_nettype wire
